// ### core/fcd_host.sv
// Host controller that issues flash command sequences over the flash bus
//
// Function
// - All cycles write except read, ID read
// - Single F0 write at any address resets
// - ID entry AA/555/90 then bank-relative read
// - Host drives bank address on ID read
// - Secured entry three writes, exit four
// - Program is four writes, last program data
// - Bypass entry AA, 55, 20
// - Bypass program is A0 then data
// - Bypass reset is 90 then 00
// - Erase six writes, 10 chip, 30 sector
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fcd_host #(
    parameter int ADDR_W = fcd_pkg::ADDR_W,
    parameter int DATA_W = fcd_pkg::DATA_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic flash_select_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic [ADDR_W-1:0] flash_addr,
    output logic [DATA_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_i,
    input wire logic ready_busy_out_n
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_NEXT}
        fcd_state_t;

    fcd_state_t state_q, state_d;
    fcd_pkg::fcd_op_t op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [2:0] step_q;
    logic [2:0] nsteps;
    logic [3:0] cnt_q;
    logic busy_q, err_q, erasing_q;
    logic [DATA_W-1:0] rdata_q;
    fcd_pkg::fcd_pins_t pins_q, pins_d;
    fcd_pkg::fcd_step_t cur;
    logic [DATA_W-1:0] dq_s1_q, dq_s2_q;
    logic rb_s1_q, rb_s2_q;
    logic rb_prev_q, rd_pend_q, pready_q, pslverr_q;
    logic [31:0] prdata_q;

    // APB decode; one wait state so the answer leaves flops
    wire access = psel && penable;
    wire wr = access && pwrite && pready_q;
    wire rd_cmd = access && !pwrite;
    wire hit_cmd = paddr == fcd_pkg::REG_CMD;
    wire hit_addr = paddr == fcd_pkg::REG_ADDR;
    wire hit_wdata = paddr == fcd_pkg::REG_WDATA;
    wire hit_stat = paddr == fcd_pkg::REG_STATUS;
    wire hit_rdata = paddr == fcd_pkg::REG_RDATA;
    wire mapped = hit_cmd || hit_addr || hit_wdata || hit_stat || hit_rdata;
    wire [fcd_pkg::CMD_W-1:0] new_cmd =
        pwdata[fcd_pkg::CMD_LSB +: fcd_pkg::CMD_W];
    wire is_suspend_cmd =
        new_cmd == 4'(fcd_pkg::FCD_OP_SUSPEND);
    // Running sector erase accepts only suspend, others flagged; a resumed erase is not tracked and accepts any command
    wire start_ok = !busy_q && (!erasing_q || is_suspend_cmd);
    wire start = wr && hit_cmd && start_ok;
    wire [31:0] stat_word = {29'h0, erasing_q,
        rb_s2_q, busy_q};

    // Bank and sector bits kept only where the sequence uses them
    wire [ADDR_W-1:0] hi = {addr_q[ADDR_W-1:12], 12'h000};
    wire [ADDR_W-1:0] ua1 = ADDR_W'(fcd_pkg::UNLOCK_A1);
    wire [ADDR_W-1:0] ua2 = ADDR_W'(fcd_pkg::UNLOCK_A2);
    wire [ADDR_W-1:0] ba1 = hi | ua1;

    function automatic fcd_pkg::fcd_step_t mk(input logic r,
        input logic [ADDR_W-1:0] a, input logic [7:0] d);
        fcd_pkg::fcd_step_t s;
        s.is_read = r;
        s.addr = a;
        s.data = d;
        return s;
    endfunction

    // Step table: sequence per operation
    always_comb begin
        cur = mk(1'b0, ADDR_W'(0), 8'h00);
        nsteps = 3'd1;
        case (op_q)
        fcd_pkg::FCD_OP_READ: cur = mk(1'b1, addr_q, 8'h00);
        fcd_pkg::FCD_OP_RESET:
            cur = mk(1'b0, addr_q, fcd_pkg::CODE_RESET);
        fcd_pkg::FCD_OP_SUSPEND:
            cur = mk(1'b0, hi, fcd_pkg::CODE_SUSPEND);
        fcd_pkg::FCD_OP_RESUME:
            cur = mk(1'b0, hi, fcd_pkg::CODE_SECTOR);
        fcd_pkg::FCD_OP_SEC_ENTER, fcd_pkg::FCD_OP_SEC_EXIT: begin
            nsteps = (op_q == fcd_pkg::FCD_OP_SEC_EXIT) ? 3'd4 : 3'd3;
            case (step_q)
            3'd0: cur = mk(1'b0, ua1, fcd_pkg::CODE_AA);
            3'd1: cur = mk(1'b0, ua2, fcd_pkg::CODE_55);
            3'd2: cur = mk(1'b0, ua1,
                (op_q == fcd_pkg::FCD_OP_SEC_EXIT) ?
                fcd_pkg::CODE_IDENT : fcd_pkg::CODE_SECURED);
            default: cur = mk(1'b0, addr_q, fcd_pkg::CODE_ZERO);
            endcase
        end
        fcd_pkg::FCD_OP_BYP_PROGRAM, fcd_pkg::FCD_OP_BYP_RESET: begin
            nsteps = 3'd2;
            if (step_q == 3'd0) begin
                cur = mk(1'b0, hi,
                    (op_q == fcd_pkg::FCD_OP_BYP_RESET) ?
                    fcd_pkg::CODE_IDENT : fcd_pkg::CODE_PROGRAM);
            end else if (op_q == fcd_pkg::FCD_OP_BYP_RESET) begin
                cur = mk(1'b0, addr_q, fcd_pkg::CODE_ZERO);
            end else begin
                cur = mk(1'b0, addr_q, wdata_q[7:0]);
            end
        end
        fcd_pkg::FCD_OP_CHIP_ERASE, fcd_pkg::FCD_OP_SECTOR_ERASE: begin
            nsteps = 3'd6;
            case (step_q)
            3'd0, 3'd3: cur = mk(1'b0, ua1, fcd_pkg::CODE_AA);
            3'd1, 3'd4: cur = mk(1'b0, ua2, fcd_pkg::CODE_55);
            3'd2: cur = mk(1'b0, ua1, fcd_pkg::CODE_ERASE);
            default: cur = (op_q == fcd_pkg::FCD_OP_CHIP_ERASE) ?
                mk(1'b0, ua1, fcd_pkg::CODE_CHIP) :
                mk(1'b0, hi, fcd_pkg::CODE_SECTOR);
            endcase
        end
        default: begin
            // Identification, program and bypass entry share unlock
            nsteps = (op_q == fcd_pkg::FCD_OP_BYP_ENTER) ? 3'd3 : 3'd4;
            case (step_q)
            3'd0: cur = mk(1'b0, ua1, fcd_pkg::CODE_AA);
            3'd1: cur = mk(1'b0, ua2, fcd_pkg::CODE_55);
            3'd2: begin
                if (op_q == fcd_pkg::FCD_OP_PROGRAM) begin
                    cur = mk(1'b0, ua1, fcd_pkg::CODE_PROGRAM);
                end else if (op_q == fcd_pkg::FCD_OP_BYP_ENTER) begin
                    cur = mk(1'b0, ua1, fcd_pkg::CODE_BYPASS);
                end else begin
                    cur = mk(1'b0, ba1, fcd_pkg::CODE_IDENT);
                end
            end
            default: begin
                case (op_q)
                fcd_pkg::FCD_OP_PROGRAM:
                    cur = mk(1'b0, addr_q, wdata_q[7:0]);
                fcd_pkg::FCD_OP_ID_MANUF: cur = mk(1'b1,
                    hi | ADDR_W'(fcd_pkg::ID_MANUF), 8'h00);
                fcd_pkg::FCD_OP_ID_PART: cur = mk(1'b1,
                    hi | ADDR_W'(fcd_pkg::ID_PART), 8'h00);
                fcd_pkg::FCD_OP_ID_LOCK: cur = mk(1'b1,
                    hi | ADDR_W'(fcd_pkg::ID_LOCK), 8'h00);
                default: cur = mk(1'b1,
                    hi | ADDR_W'(fcd_pkg::ID_PROTECT), 8'h00);
                endcase
            end
            endcase
        end
        endcase
        if (op_q == fcd_pkg::FCD_OP_RESET && addr_q[11:0] ==
            fcd_pkg::QUERY_ADDR && wdata_q[7:0] == fcd_pkg::CODE_QUERY) begin
            // Query entry rides on reset slot with code 98 at 55
            cur = mk(1'b0, ADDR_W'(fcd_pkg::QUERY_ADDR),
                fcd_pkg::CODE_QUERY);
        end
    end

    wire last_cnt = cnt_q == 4'(fcd_pkg::PHASE_CYC - 1);
    wire last_step = step_q == nsteps - 3'd1;
    // Program data is the one write that uses the full bus width
    wire pd_step = (op_q == fcd_pkg::FCD_OP_PROGRAM && step_q == 3'd3) ||
        (op_q == fcd_pkg::FCD_OP_BYP_PROGRAM && step_q == 3'd1);

    // Bus cycle: setup, strobe low, hold; address stays over all
    always_comb begin
        state_d = state_q;
        pins_d = pins_q;
        case (state_q)
        S_IDLE: if (start) state_d = S_SETUP;
        S_SETUP: begin
            pins_d.cs_n = 1'b0;
            pins_d.addr = cur.addr;
            pins_d.dq_out = pd_step ? wdata_q : {8'h00, cur.data};
            pins_d.dq_oe = !cur.is_read;
            if (last_cnt) state_d = S_STROBE;
        end
        S_STROBE: begin
            pins_d.we_n = cur.is_read;
            pins_d.oe_n = !cur.is_read;
            if (last_cnt) state_d = S_HOLD;
        end
        S_HOLD: begin
            // Strobes rise while data still driven
            pins_d.we_n = 1'b1;
            pins_d.oe_n = 1'b1;
            if (last_cnt) state_d = S_NEXT;
        end
        S_NEXT: begin
            pins_d.cs_n = 1'b1;
            pins_d.dq_oe = 1'b0;
            state_d = last_step ? S_IDLE : S_SETUP;
        end
        default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            rb_s1_q <= 1'b1;
            rb_s2_q <= 1'b1;
            rb_prev_q <= 1'b1;
        end else begin
            dq_s1_q <= dq_i;
            dq_s2_q <= dq_s1_q;
            rb_s1_q <= ready_busy_out_n;
            rb_s2_q <= rb_s1_q;
            rb_prev_q <= rb_s2_q;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= S_IDLE;
            pins_q <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                addr: '0, dq_out: '0, dq_oe: 1'b0};
            cnt_q <= 4'h0;
            step_q <= 3'd0;
        end else begin
            state_q <= state_d;
            pins_q <= pins_d;
            cnt_q <= (state_d != state_q) ? 4'h0 : cnt_q + 4'h1;
            if (state_q == S_IDLE) begin
                step_q <= 3'd0;
            end else if (state_q == S_NEXT) begin
                step_q <= step_q + 3'd1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_q <= fcd_pkg::FCD_OP_READ;
            addr_q <= '0;
            wdata_q <= '0;
            rd_pend_q <= 1'b0;
            busy_q <= 1'b0;
            err_q <= 1'b0;
            erasing_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            if (wr && hit_addr) addr_q <= pwdata[ADDR_W-1:0];
            if (wr && hit_wdata) wdata_q <= pwdata[DATA_W-1:0];
            if (wr && hit_cmd) begin
                err_q <= !start_ok;
            end
            if (start) begin
                op_q <= fcd_pkg::fcd_op_t'(new_cmd);
                busy_q <= 1'b1;
            end else if (state_q == S_NEXT && last_step) begin
                busy_q <= 1'b0;
                if (op_q == fcd_pkg::FCD_OP_SECTOR_ERASE) begin
                    erasing_q <= 1'b1;
                end else if (op_q == fcd_pkg::FCD_OP_SUSPEND) begin
                    erasing_q <= 1'b0;
                end
            end else if (erasing_q && rb_s2_q && !rb_prev_q &&
                state_q == S_IDLE &&
                op_q == fcd_pkg::FCD_OP_SECTOR_ERASE) begin
                // A rise of ready, not its level, ends it here; the old level lags the start
                erasing_q <= 1'b0;
            end
            // Bus seen under the strobe reaches dq_s2_q two edges later
            rd_pend_q <= state_q == S_NEXT && cur.is_read;
            if (rd_pend_q) begin
                rdata_q <= dq_s2_q;
            end
        end
    end

    wire [31:0] rd_word = hit_stat ? (stat_word | {28'h0, err_q, 3'h0}) :
        hit_rdata ? 32'(rdata_q) : hit_addr ? 32'(addr_q) :
        hit_wdata ? 32'(wdata_q) : 32'h0;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= access && !pready_q;
            pslverr_q <= access && !pready_q && !mapped;
            prdata_q <= (rd_cmd && !pready_q) ? rd_word : 32'h0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign flash_select_n = pins_q.cs_n;
    assign write_strobe_n = pins_q.we_n;
    assign output_enable_n = pins_q.oe_n;
    assign flash_addr = pins_q.addr;
    assign dq_o = pins_q.dq_out;
    assign dq_oe = pins_q.dq_oe;
endmodule
`default_nettype wire

// ### dv/fcd_flash_model.sv
// Behavioural flash part answering the controller's bus cycles
`timescale 1ns/1ps
`default_nettype none
module fcd_flash_model #(
    parameter logic [7:0] MANUF_ID = 8'h3C, // Arbitrary value
    parameter logic [7:0] PART_ID = 8'h6B, // Arbitrary value
    parameter bit LOCKED = 1'b1,
    parameter bit PROT = 1'b1
) (
    input wire logic flash_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] dq_o,
    output logic [15:0] dq_i,
    output var logic ready_busy_out_n
);
    logic [20:0] la;
    logic [7:0] h0 = 8'h00, h1 = 8'h00, idv;
    logic act = 1'b0, idm = 1'b0, sus = 1'b0;
    logic [15:0] rdv, held = 16'h0000;
    wire logic [7:0] c = dq_o[7:0];
    initial ready_busy_out_n = 1'b1;
    // Later of the two falling strobes takes the address
    always @(negedge write_strobe_n or negedge flash_select_n) begin
        if (!write_strobe_n && !flash_select_n) begin
            la = flash_addr;
            act = 1'b1;
        end
    end
    // First rising strobe takes the data
    always @(posedge write_strobe_n or posedge flash_select_n) begin
        if (act) begin
            act = 1'b0;
            if (h0 == 8'h90 && c == 8'h00) idm = 1'b0;
            else if (c == 8'hF0) idm = 1'b0;
            else if (h1 == 8'hAA && h0 == 8'h55 && c == 8'h90) idm = 1'b1;
            else if (h0 == 8'h55 && c == 8'h30) ready_busy_out_n = 1'b0;
            else if (c == 8'hB0 && !ready_busy_out_n) begin
                ready_busy_out_n = 1'b1;
                sus = 1'b1;
            end else if (c == 8'h30 && sus) begin
                ready_busy_out_n = 1'b0;
                sus = 1'b0;
            end
            h1 = h0;
            h0 = c;
        end
    end
    // Sector bits ignored for the offset
    assign idv = flash_addr[7:0] == 8'h00 ? MANUF_ID
        : flash_addr[7:0] == 8'h02 ? PART_ID
        : flash_addr[7:0] == 8'h06 ? (LOCKED ? 8'h80 : 8'h00)
        : (PROT ? 8'h01 : 8'h00);
    assign rdv = idm ? {8'h00, idv} : {flash_addr[7:0], ~flash_addr[15:8]};
    // Released bus shows the inverse so a late sample cannot pass by luck
    assign dq_i = (!output_enable_n && !flash_select_n) ? rdv : ~held;
    always @(posedge output_enable_n) held = rdv;
endmodule
`default_nettype wire

// ### dv/fcd_host_props.sv
// Pin-level checks on the flash bus of the command controller
`timescale 1ns/1ps
`default_nettype none
module fcd_host_props #(
    parameter int ADDR_W = 21,
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flash_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic [DATA_W-1:0] dq_o,
    input wire logic dq_oe
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence wr_tail_s;
        !write_strobe_n ##1 write_strobe_n && !flash_select_n
            ##1 flash_select_n && !dq_oe;
    endsequence
    sequence rd_tail_s;
        !output_enable_n && !dq_oe
            ##1 output_enable_n && !flash_select_n ##1 flash_select_n;
    endsequence
    write_cycle_a: assert property ($fell(flash_select_n) && dq_oe |=> wr_tail_s)
        else $error("write cycle shape wrong");
    read_cycle_a: assert property ($fell(flash_select_n) && !dq_oe |=> rd_tail_s)
        else $error("read cycle shape wrong");
    wr_hold_a: assert property ($fell(write_strobe_n) |=> $stable(flash_addr) && $stable(dq_o))
        else $error("address or data moved during write strobe");
    rd_hold_a: assert property ($fell(output_enable_n) |=> $stable(flash_addr))
        else $error("address moved during read strobe");
    strobe_excl_a: assert property (write_strobe_n || output_enable_n)
        else $error("write and read strobes low together");
    wr_drive_a: assert property (!write_strobe_n |-> dq_oe && !flash_select_n)
        else $error("write strobe without driven data");
    rd_float_a: assert property (!output_enable_n |-> !dq_oe && !flash_select_n)
        else $error("host drives data during read");
    idle_quiet_a: assert property (flash_select_n |-> write_strobe_n && output_enable_n)
        else $error("strobe low while deselected");
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ev;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, cs_n, we_n, oe_n, dq_oe, rb_n;
    logic [20:0] faddr, am, ra;
    logic [15:0] dq_o, dq_i;
    logic [36:0] wq[$];
    logic [7:0] idx[4] = '{8'h3C, 8'h6B, 8'h80, 8'h01};
    int fail_count = 0, samples_checked = 0, cyc = 0;
    initial forever #50 sys_clk = ~sys_clk;
    fcd_host DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_select_n(cs_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .flash_addr(faddr), .dq_o(dq_o),
        .dq_oe(dq_oe), .dq_i(dq_i), .ready_busy_out_n(rb_n));
    fcd_flash_model u_flash (.flash_select_n(cs_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .flash_addr(faddr), .dq_o(dq_o),
        .dq_i(dq_i), .ready_busy_out_n(rb_n));
    always @(posedge we_n) if (!cs_n) wq.push_back({faddr, dq_o});
    always @(negedge oe_n) ra = faddr;
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            conclude();
        end
    end
    task automatic chk(input string n, input logic [36:0] s,
        input logic [36:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Busy is polled, never assumed to clear in a set time
    task automatic cmd(input logic [3:0] op, input logic [20:0] a,
        input logic [15:0] d);
        apb(1'b1, fcd_pkg::REG_ADDR, {11'h000, a});
        apb(1'b1, fcd_pkg::REG_WDATA, {16'h0000, d});
        apb(1'b1, fcd_pkg::REG_CMD, {28'h0000000, op});
        do apb(1'b0, fcd_pkg::REG_STATUS, 32'h0); while (rv[0] !== 1'b0);
    endtask
    task automatic ew(input logic [20:0] a, input logic [15:0] d);
        logic [36:0] s;
        s = (wq.size() > 0) ? wq.pop_front() : 'x;
        chk("flash write", {s[36:16] & am, s[15:0]}, {a & am, d});
    endtask
    // Unlock pair then a code at the first unlock address
    task automatic uc(input logic [15:0] d);
        am = 21'h000FFF;
        ew(21'h000AAA, 16'h00AA);
        ew(21'h000555, 16'h0055);
        ew(21'h000AAA, d);
    endtask
    task automatic done(input string n);
        chk("spare writes", 37'(wq.size()), 37'h0);
        $display("test %s finished", n);
    endtask
    initial begin
        am = 21'h000FFF;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        cmd(4'h0, 21'h012345, 16'h0000);
        apb(1'b0, fcd_pkg::REG_RDATA, 32'h0);
        chk("array read", rv, 32'h000045DC);
        done("read");
        cmd(4'h8, 21'h00ABCD, 16'hBEEF);
        uc(16'h00A0);
        am = 21'h1FFFFF;
        ew(21'h00ABCD, 16'hBEEF);
        done("program");
        for (int i = 0; i < 4; i++) begin
            cmd(4'(i + 2), 21'h1F0000, 16'h0000);
            am = 21'h000FFF;
            ew(21'h000AAA, 16'h00AA);
            ew(21'h000555, 16'h0055);
            am = 21'h1FFFFF;
            ew(21'h1F0AAA, 16'h0090);
            chk("id bank", ra[20:12], 9'h1F0);
            apb(1'b0, fcd_pkg::REG_RDATA, 32'h0);
            chk("id data", rv[7:0], idx[i]);
            cmd(4'h1, 21'h000000, 16'h0000);
            am = 21'h0;
            ew(21'h0, 16'h00F0);
        end
        done("identification");
        cmd(4'h1, 21'h000055, 16'h0098);
        am = 21'h000FFF;
        ew(21'h000055, 16'h0098);
        cmd(4'h6, 21'h0, 16'h0);
        uc(16'h0088);
        cmd(4'h7, 21'h0, 16'h0);
        uc(16'h0090);
        am = 21'h0;
        ew(21'h0, 16'h0000);
        done("query and secured");
        cmd(4'h9, 21'h0, 16'h0);
        uc(16'h0020);
        cmd(4'hA, 21'h001234, 16'h5A5A);
        am = 21'h0;
        ew(21'h0, 16'h00A0);
        am = 21'h1FFFFF;
        ew(21'h001234, 16'h5A5A);
        cmd(4'hB, 21'h0, 16'h0);
        am = 21'h0;
        ew(21'h0, 16'h0090);
        ew(21'h0, 16'h0000);
        done("bypass");
        cmd(4'hD, 21'h0A5000, 16'h0);
        uc(16'h0080);
        ew(21'h000AAA, 16'h00AA);
        ew(21'h000555, 16'h0055);
        am = 21'h1FF000;
        ew(21'h0A5000, 16'h0030);
        chk("erasing", rv[2], 1'b1);
        cmd(4'h8, 21'h0, 16'h1111);
        chk("refused", rv[3], 1'b1);
        cmd(4'hE, 21'h0A5000, 16'h0);
        ew(21'h0A5000, 16'h00B0);
        cmd(4'hF, 21'h0A5000, 16'h0);
        ew(21'h0A5000, 16'h0030);
        cmd(4'hC, 21'h0, 16'h0);
        uc(16'h0080);
        ew(21'h000AAA, 16'h00AA);
        ew(21'h000555, 16'h0055);
        ew(21'h000AAA, 16'h0010);
        done("erase");
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", ev, 1'b1);
        $display("test unmapped finished");
        conclude();
    end
endmodule
bind fcd_host fcd_host_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_props (
    .sys_clk(sys_clk), .rst(rst), .flash_select_n(flash_select_n),
    .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe));
`default_nettype wire

// ### pkg/fcd_pkg.sv
// Constants and carrier types for the flash command controller
package fcd_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    // APB register offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    // Command field of REG_CMD
    localparam int CMD_LSB = 0;
    localparam int CMD_W = 4;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RB_BIT = 1;
    // Unlock addresses and codes, byte mode
    localparam logic [11:0] UNLOCK_A1 = 12'hAAA;
    localparam logic [11:0] UNLOCK_A2 = 12'h555;
    localparam logic [11:0] QUERY_ADDR = 12'h055;
    localparam logic [7:0] CODE_AA = 8'hAA;
    localparam logic [7:0] CODE_55 = 8'h55;
    localparam logic [7:0] CODE_RESET = 8'hF0;
    localparam logic [7:0] CODE_IDENT = 8'h90;
    localparam logic [7:0] CODE_SECURED = 8'h88;
    localparam logic [7:0] CODE_PROGRAM = 8'hA0;
    localparam logic [7:0] CODE_BYPASS = 8'h20;
    localparam logic [7:0] CODE_ERASE = 8'h80;
    localparam logic [7:0] CODE_CHIP = 8'h10;
    localparam logic [7:0] CODE_SECTOR = 8'h30;
    localparam logic [7:0] CODE_SUSPEND = 8'hB0;
    localparam logic [7:0] CODE_QUERY = 8'h98;
    localparam logic [7:0] CODE_ZERO = 8'h00;
    // Identification read offsets
    localparam logic [11:0] ID_MANUF = 12'h000;
    localparam logic [11:0] ID_PART = 12'h002;
    localparam logic [11:0] ID_PROTECT = 12'h004;
    localparam logic [11:0] ID_LOCK = 12'h006;
    // Bus cycle phase length in sys_clk cycles (100 ns each)
    localparam int T_PHASE_NS = 100;
    localparam int CLK_NS = 100;
    localparam int PHASE_CYC = (T_PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAX_STEPS = 6;

    typedef enum logic [3:0] {
        FCD_OP_READ, FCD_OP_RESET, FCD_OP_ID_MANUF, FCD_OP_ID_PART,
        FCD_OP_ID_LOCK, FCD_OP_ID_PROTECT, FCD_OP_SEC_ENTER,
        FCD_OP_SEC_EXIT, FCD_OP_PROGRAM, FCD_OP_BYP_ENTER,
        FCD_OP_BYP_PROGRAM, FCD_OP_BYP_RESET, FCD_OP_CHIP_ERASE,
        FCD_OP_SECTOR_ERASE, FCD_OP_SUSPEND, FCD_OP_RESUME
    } fcd_op_t;

    typedef struct packed {
        logic is_read;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fcd_step_t;

    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } fcd_pins_t;
endpackage
